// ---- shared/tap_setup_pkg.sv ----
// Purpose: Shared constants and types for the setup instruction decoder behind the test port.
// Assumes: Six-bit instruction codes; the test clock is sampled by the 20 MHz system clock.
// Notes:   Every code, width, reset value and timing figure is named once here.

package tap_setup_pkg;

	// ----------------------------------------------------------------
	// Register widths
	// ----------------------------------------------------------------
	localparam int IR_W    = 6;
	localparam int ID_W    = 32;
	localparam int FULL_W  = 112;
	localparam int QUICK_W = 40;
	localparam int SIG_W   = 16;

	// ----------------------------------------------------------------
	// Instruction codes
	// ----------------------------------------------------------------
	localparam logic [5:0] EXTERNAL_TEST_CMD             = 6'h00;
	localparam logic [5:0] SELECT_FULL_SETUP_CMD         = 6'h01;
	localparam logic [5:0] SELECT_QUICK_SETUP_CMD        = 6'h02;
	localparam logic [5:0] SELECT_SIGNATURE_CMD          = 6'h03;
	localparam logic [5:0] LOAD_SRAM_FROM_SHIFT_CMD      = 6'h05;
	localparam logic [5:0] FETCH_SETUP_MEMORY_CMD        = 6'h06;
	localparam logic [5:0] FETCH_SIGNATURE_MEMORY_CMD    = 6'h0a;
	localparam logic [5:0] WRITE_SIGNATURE_MEMORY_CMD    = 6'h0b;
	localparam logic [5:0] WRITE_SETUP_MEMORY_CMD        = 6'h0c;
	localparam logic [5:0] IDENTIFY_CMD                  = 6'h0d;
	localparam logic [5:0] SET_READOUT_LOCK_CMD          = 6'h11;
	localparam logic [5:0] SLEEP_ANALOG_CMD              = 6'h12;
	localparam logic [5:0] WAKE_ANALOG_CMD               = 6'h13;
	localparam logic [5:0] RESTORE_SRAM_FROM_MEMORY_CMD  = 6'h16;
	localparam logic [5:0] CLEAR_SETUP_MEMORY_CMD        = 6'h17;
	localparam logic [5:0] CLEAR_SIGNATURE_MEMORY_CMD    = 6'h1b;
	localparam logic [5:0] START_AUTOCALIBRATION_CMD     = 6'h1c;
	localparam logic [5:0] BULK_CLEAR_ALL_CMD            = 6'h1d;
	localparam logic [5:0] SAMPLE_PRELOAD_CMD            = 6'h1e;
	localparam logic [5:0] BYPASS_CMD                    = 6'h3f;

	// ----------------------------------------------------------------
	// Capture and reset values
	// ----------------------------------------------------------------
	localparam logic [5:0]   IR_CAPTURE_VALUE = 6'h0d;
	localparam logic [5:0]   INSTR_RESET      = 6'h0d;
	localparam logic [111:0] SETUP_RESET      = 112'h0;
	localparam logic [15:0]  SIG_RESET        = 16'h0;
	localparam logic [111:0] SRAM_RESET       = 112'h0;

	// ----------------------------------------------------------------
	// Deferred command queue and timing
	// ----------------------------------------------------------------
	localparam int CMD_FIFO_DEPTH = 4;
	localparam int CLK_PERIOD_NS  = 50;
	localparam int SWITCH_TIME_NS = 1000;
	localparam int SWITCH_CYCLES  = SWITCH_TIME_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		TEST_RESET, RUN_IDLE,
		SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
		SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
	} tap_state_t;

	typedef enum logic [2:0] {
		PATH_BYPASS, PATH_ID, PATH_FULL, PATH_QUICK, PATH_SIG
	} path_t;

endpackage

// ---- logic/pin_sync.sv ----
// Purpose: Two-stage synchroniser with edge detection for asynchronous pins.
// Assumes: Pins change slowly compared with i_clk.
// Notes:   Edges are found on the second and third stages only.

module pin_sync #(
	parameter int W = 3
) (
	// Clock and reset.
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	// Raw pins.
	input  wire logic [W-1:0] i_pins,
	// Synchronised levels and one-cycle edge pulses.
	output logic      [W-1:0] o_level,
	output logic      [W-1:0] o_rise,
	output logic      [W-1:0] o_fall
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
		logic [W-1:0] last;
	} sync_state_t;

	sync_state_t s;
	sync_state_t next_s;

	// The first stage feeds only the second stage.
	always_comb begin
		next_s        = s;
		next_s.meta   = i_pins;
		next_s.stable = s.meta;
		next_s.last   = s.stable;
	end

	// State register.
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Edges compare the settled stage with the one behind it.
	assign o_level = s.stable;
	assign o_rise  = s.stable & ~s.last;
	assign o_fall  = ~s.stable & s.last;

endmodule

// ---- logic/cmd_fifo.sv ----
// Purpose: Small first-in first-out queue with valid and ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Push and pop in one cycle are allowed when neither side is blocked.

module cmd_fifo #(
	parameter int WIDTH = 6,
	parameter int DEPTH = 4
) (
	// Clock and reset.
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	// Filling side.
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Draining side.
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr;
		logic [PW-1:0]               rd;
		logic [CW-1:0]               count;
	} fifo_state_t;

	fifo_state_t s;
	fifo_state_t next_s;
	logic        push;
	logic        pop;

	// Full and empty come straight from the occupancy count.
	assign o_in_ready  = (s.count != FULL_COUNT);
	assign o_out_valid = (s.count != '0);
	assign o_out_data  = s.mem[s.rd];
	assign push        = i_in_valid & o_in_ready;
	assign pop         = o_out_valid & i_out_ready;

	// Pointer and count update.
	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wr] = i_in_data;
			next_s.wr        = s.wr + PW'(1);
		end
		if (pop) begin
			next_s.rd = s.rd + PW'(1);
		end
		if (push && !pop) begin
			next_s.count = s.count + CW'(1);
		end else if (pop && !push) begin
			next_s.count = s.count - CW'(1);
		end
	end

	// State register.
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule

// ---- logic/tap_setup_instruction_decoder.sv ----
// Purpose: Test port instruction decoder, data path selection and deferred command execution.
// Assumes: Test clock, mode select and data in are asynchronous pins sampled by i_clk.
//          i_cal_done and i_nv_busy come from logic on i_clk.
// Notes:   Nonvolatile cells are modelled as registers that update when a command is drained.
//
// Operation
// R1: Instruction register is six bits; controller shifts exactly six bits per IR scan.
// R2: Any code with leading one selects the single bypass stage.
// R3: Codes 000000 and 011110 select bypass; there is no boundary register.
// R4: Code 001101 selects the 32-bit identification register without disturbing operation.
// R5: Identification register is readable right after reset without loading an instruction.
// R6: Code 000001 selects the 112-bit full setup register for data scans.
// R7: Code 000010 selects the 40-bit quick setup register for data scans.
// R8: Code 000011 selects the 16-bit signature register for data scans.
// R9: The selected register shifts from serial input during data shifting.
// R10: Codes 001011 and 001100 write signature and setup registers into memory.
// R11: Code 010001 sets the readout lock; locked setup data never shifts out.
// R12: Bulk clear 011101 zeroes setup, signature and lock; only way to clear lock.
// R13: Code 000101 loads setup register into SRAM, whole or quick portion.
// R14: Code 010110 reloads control SRAM from stored setup memory.
// R15: SRAM loads take effect well under one microsecond after idle entry; here they wait while i_nv_busy is high.
// R16: Codes 000110 and 001010 fetch setup and signature memory into registers.
// R17: Code 011100 starts calibration; amplifiers held at zero until done.
// R18: Codes 010010 and 010011 enter and leave analog power-down.
// R19: Codes 010111 and 011011 clear setup and signature memory to zero.
// R20: Memory writes only set bits; controller must clear before writing.
// R21: Program, clear, load, power and calibration act at idle entry; others at update.
// R22: Controller should finish in test-logic-reset with clock and mode idle.
// R23: Bypass is one stage giving one test clock of delay.
// R24: Unassigned leading-zero codes select bypass and do nothing.

module tap_setup_instruction_decoder #(
	// Identification value; arbitrary, low bit set as the test standard expects.
	parameter logic [31:0] ID_VALUE = 32'h0a5a_5001
) (
	// Clock and reset.
	input  wire logic          i_clk,
	input  wire logic          i_reset,
	// Test port pins.
	input  wire logic          i_tck,
	input  wire logic          i_tms,
	input  wire logic          i_tdi,
	output logic               o_tdo,
	output logic               o_tdo_oe,
	// Analog and memory handshakes.
	input  wire logic          i_cal_done,
	input  wire logic          i_nv_busy,
	// Device control outputs.
	output logic [111:0]       o_control_sram,
	output logic               o_amp_hold_zero,
	output logic               o_analog_sleep,
	output logic               o_readout_lock,
	output logic [5:0]         o_instruction
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		tap_setup_pkg::tap_state_t tap;
		logic [5:0]                ir_sr;
		logic [5:0]                instr;
		logic                      bypass;
		logic [31:0]               id_sr;
		logic [111:0]              setup_sr;
		logic [15:0]               sig_sr;
		logic                      last_quick;
		logic [111:0]              setup_nv;
		logic [15:0]               sig_nv;
		logic                      lock;
		logic [111:0]              sram;
		logic                      sleep;
		logic                      cal;
		logic                      tdo;
		logic                      tdo_oe;
		logic                      pend_valid;
		logic [5:0]                pend_cmd;
	} dec_state_t;

	dec_state_t s;
	dec_state_t next_s;

	logic [2:0] pin_level;
	logic [2:0] pin_rise;
	logic [2:0] pin_fall;
	logic       tck_rise;
	logic       tck_fall;
	logic       tms;
	logic       tdi;
	logic       q_in_ready;
	logic       q_out_valid;
	logic [5:0] q_out_data;
	logic       q_out_ready;

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------

	// Data path chosen by an instruction; anything unlisted falls to bypass.
	function automatic tap_setup_pkg::path_t path_of(input logic [5:0] code);
		path_of = tap_setup_pkg::PATH_BYPASS; // R2 R3 R24
		if (!code[5]) begin
			case (code)
				tap_setup_pkg::IDENTIFY_CMD:           path_of = tap_setup_pkg::PATH_ID;    // R4
				tap_setup_pkg::SELECT_FULL_SETUP_CMD:  path_of = tap_setup_pkg::PATH_FULL;  // R6
				tap_setup_pkg::SELECT_QUICK_SETUP_CMD: path_of = tap_setup_pkg::PATH_QUICK; // R7
				tap_setup_pkg::SELECT_SIGNATURE_CMD:   path_of = tap_setup_pkg::PATH_SIG;   // R8
				default:                               path_of = tap_setup_pkg::PATH_BYPASS;
			endcase
		end
	endfunction

	// Instructions that wait for idle entry before acting.
	function automatic logic is_deferred(input logic [5:0] code);
		case (code)
			tap_setup_pkg::WRITE_SIGNATURE_MEMORY_CMD,
			tap_setup_pkg::WRITE_SETUP_MEMORY_CMD,
			tap_setup_pkg::SET_READOUT_LOCK_CMD,
			tap_setup_pkg::SLEEP_ANALOG_CMD,
			tap_setup_pkg::WAKE_ANALOG_CMD,
			tap_setup_pkg::LOAD_SRAM_FROM_SHIFT_CMD,
			tap_setup_pkg::RESTORE_SRAM_FROM_MEMORY_CMD,
			tap_setup_pkg::CLEAR_SETUP_MEMORY_CMD,
			tap_setup_pkg::CLEAR_SIGNATURE_MEMORY_CMD,
			tap_setup_pkg::BULK_CLEAR_ALL_CMD,
			tap_setup_pkg::START_AUTOCALIBRATION_CMD: is_deferred = 1'b1; // R21
			default:                                  is_deferred = 1'b0;
		endcase
	endfunction

	// Standard sixteen-state test port controller walk.
	function automatic tap_setup_pkg::tap_state_t tap_next(input tap_setup_pkg::tap_state_t st,
	                                                       input logic m);
		case (st)
			tap_setup_pkg::TEST_RESET: tap_next = m ? tap_setup_pkg::TEST_RESET : tap_setup_pkg::RUN_IDLE;
			tap_setup_pkg::RUN_IDLE:   tap_next = m ? tap_setup_pkg::SELECT_DR  : tap_setup_pkg::RUN_IDLE;
			tap_setup_pkg::SELECT_DR:  tap_next = m ? tap_setup_pkg::SELECT_IR  : tap_setup_pkg::CAPTURE_DR;
			tap_setup_pkg::CAPTURE_DR: tap_next = m ? tap_setup_pkg::EXIT1_DR   : tap_setup_pkg::SHIFT_DR;
			tap_setup_pkg::SHIFT_DR:   tap_next = m ? tap_setup_pkg::EXIT1_DR   : tap_setup_pkg::SHIFT_DR;
			tap_setup_pkg::EXIT1_DR:   tap_next = m ? tap_setup_pkg::UPDATE_DR  : tap_setup_pkg::PAUSE_DR;
			tap_setup_pkg::PAUSE_DR:   tap_next = m ? tap_setup_pkg::EXIT2_DR   : tap_setup_pkg::PAUSE_DR;
			tap_setup_pkg::EXIT2_DR:   tap_next = m ? tap_setup_pkg::UPDATE_DR  : tap_setup_pkg::SHIFT_DR;
			tap_setup_pkg::UPDATE_DR:  tap_next = m ? tap_setup_pkg::SELECT_DR  : tap_setup_pkg::RUN_IDLE;
			tap_setup_pkg::SELECT_IR:  tap_next = m ? tap_setup_pkg::TEST_RESET : tap_setup_pkg::CAPTURE_IR;
			tap_setup_pkg::CAPTURE_IR: tap_next = m ? tap_setup_pkg::EXIT1_IR   : tap_setup_pkg::SHIFT_IR;
			tap_setup_pkg::SHIFT_IR:   tap_next = m ? tap_setup_pkg::EXIT1_IR   : tap_setup_pkg::SHIFT_IR;
			tap_setup_pkg::EXIT1_IR:   tap_next = m ? tap_setup_pkg::UPDATE_IR  : tap_setup_pkg::PAUSE_IR;
			tap_setup_pkg::PAUSE_IR:   tap_next = m ? tap_setup_pkg::EXIT2_IR   : tap_setup_pkg::PAUSE_IR;
			tap_setup_pkg::EXIT2_IR:   tap_next = m ? tap_setup_pkg::UPDATE_IR  : tap_setup_pkg::SHIFT_IR;
			tap_setup_pkg::UPDATE_IR:  tap_next = m ? tap_setup_pkg::SELECT_DR  : tap_setup_pkg::RUN_IDLE;
			default:                   tap_next = tap_setup_pkg::TEST_RESET;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers and deferred command queue
	// ----------------------------------------------------------------
	pin_sync #(
		.W (3)
	) u_pin_sync (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_pins  ({i_tck, i_tms, i_tdi}),
		.o_level (pin_level),
		.o_rise  (pin_rise),
		.o_fall  (pin_fall)
	);

	// Mode select and data in share the clock's delay, so they are read at its edge.
	assign tck_rise = pin_rise[2];
	assign tck_fall = pin_fall[2];
	assign tms      = pin_level[1];
	assign tdi      = pin_level[0];

	// The drain stalls while the nonvolatile cells are busy, so the queue really fills.
	assign q_out_ready = ~i_nv_busy;

	cmd_fifo #(
		.WIDTH (tap_setup_pkg::IR_W),
		.DEPTH (tap_setup_pkg::CMD_FIFO_DEPTH)
	) u_cmd_fifo (
		.i_clk       (i_clk),
		.i_reset     (i_reset),
		.i_in_valid  (s.pend_valid),
		.i_in_data   (s.pend_cmd),
		.o_in_ready  (q_in_ready),
		.o_out_valid (q_out_valid),
		.o_out_data  (q_out_data),
		.i_out_ready (q_out_ready)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------

	// Test clock rising edge: capture, shift, update and controller step.
	// Falling edge: serial output moves, as a chained device downstream expects.
	always_comb begin
		next_s = s;

		// Pending command is handed to the queue when it has room.
		if (s.pend_valid && q_in_ready) begin
			next_s.pend_valid = 1'b0;
		end

		if (tck_rise) begin
			case (s.tap)
				tap_setup_pkg::TEST_RESET: begin
					next_s.instr = tap_setup_pkg::INSTR_RESET; // R5
				end
				tap_setup_pkg::CAPTURE_IR: begin
					next_s.ir_sr = tap_setup_pkg::IR_CAPTURE_VALUE;
				end
				tap_setup_pkg::SHIFT_IR: begin
					next_s.ir_sr = {tdi, s.ir_sr[5:1]}; // R1
				end
				tap_setup_pkg::UPDATE_IR: begin
					next_s.instr = s.ir_sr; // R21
					case (s.ir_sr)
						tap_setup_pkg::SELECT_FULL_SETUP_CMD:      next_s.last_quick = 1'b0;
						tap_setup_pkg::SELECT_QUICK_SETUP_CMD:     next_s.last_quick = 1'b1;
						tap_setup_pkg::FETCH_SETUP_MEMORY_CMD:     next_s.setup_sr   = s.setup_nv; // R16
						tap_setup_pkg::FETCH_SIGNATURE_MEMORY_CMD: next_s.sig_sr     = s.sig_nv;   // R16
						default:                                   next_s.last_quick = s.last_quick;
					endcase
				end
				tap_setup_pkg::CAPTURE_DR: begin
					case (path_of(s.instr))
						tap_setup_pkg::PATH_ID: next_s.id_sr  = ID_VALUE; // R4
						default:                next_s.bypass = 1'b0;
					endcase
				end
				tap_setup_pkg::SHIFT_DR: begin
					case (path_of(s.instr)) // R9
						tap_setup_pkg::PATH_ID:    next_s.id_sr = {tdi, s.id_sr[31:1]};
						tap_setup_pkg::PATH_FULL:  next_s.setup_sr = {tdi, s.setup_sr[tap_setup_pkg::FULL_W-1:1]};
						tap_setup_pkg::PATH_QUICK: begin
							next_s.setup_sr[tap_setup_pkg::QUICK_W-1:0] =
								{tdi, s.setup_sr[tap_setup_pkg::QUICK_W-1:1]};
						end
						tap_setup_pkg::PATH_SIG:   next_s.sig_sr = {tdi, s.sig_sr[tap_setup_pkg::SIG_W-1:1]};
						default:                   next_s.bypass = tdi; // R23
					endcase
				end
				default: begin
					next_s.bypass = s.bypass;
				end
			endcase

			next_s.tap = tap_next(s.tap, tms);

			// Deferred commands are queued on entry to idle; a second one before
			// the first is queued is dropped, which a controller at test clock
			// rates provokes only while the queue is full.
			if (next_s.tap == tap_setup_pkg::RUN_IDLE && s.tap != tap_setup_pkg::RUN_IDLE &&
			    is_deferred(next_s.instr) && !next_s.pend_valid) begin // R21
				next_s.pend_valid = 1'b1;
				next_s.pend_cmd   = next_s.instr;
			end
		end

		if (tck_fall) begin
			next_s.tdo_oe = (s.tap == tap_setup_pkg::SHIFT_IR) || (s.tap == tap_setup_pkg::SHIFT_DR);
			if (s.tap == tap_setup_pkg::SHIFT_IR) begin
				next_s.tdo = s.ir_sr[0];
			end else begin
				case (path_of(s.instr))
					tap_setup_pkg::PATH_ID:    next_s.tdo = s.id_sr[0];
					tap_setup_pkg::PATH_FULL,
					tap_setup_pkg::PATH_QUICK: next_s.tdo = s.setup_sr[0] & ~s.lock; // R11
					tap_setup_pkg::PATH_SIG:   next_s.tdo = s.sig_sr[0];
					default:                   next_s.tdo = s.bypass; // R23
				endcase
			end
		end

		// Calibration ends on its done flag; a fresh start below wins over it.
		if (i_cal_done) begin
			next_s.cal = 1'b0;
		end

		// Drained command executes within a few cycles of idle entry unless i_nv_busy stalls the drain.
		if (q_out_valid && q_out_ready) begin // R15
			case (q_out_data)
				tap_setup_pkg::WRITE_SIGNATURE_MEMORY_CMD: next_s.sig_nv   = s.sig_nv | s.sig_sr;     // R10 R20
				tap_setup_pkg::WRITE_SETUP_MEMORY_CMD:     next_s.setup_nv = s.setup_nv | s.setup_sr; // R10 R20
				tap_setup_pkg::SET_READOUT_LOCK_CMD:       next_s.lock     = 1'b1;                    // R11
				tap_setup_pkg::BULK_CLEAR_ALL_CMD: begin                                              // R12
					next_s.setup_nv = tap_setup_pkg::SETUP_RESET;
					next_s.sig_nv   = tap_setup_pkg::SIG_RESET;
					next_s.lock     = 1'b0;
				end
				tap_setup_pkg::LOAD_SRAM_FROM_SHIFT_CMD: begin // R13
					if (s.last_quick) begin
						next_s.sram[tap_setup_pkg::QUICK_W-1:0] = s.setup_sr[tap_setup_pkg::QUICK_W-1:0];
					end else begin
						next_s.sram = s.setup_sr;
					end
				end
				tap_setup_pkg::RESTORE_SRAM_FROM_MEMORY_CMD: next_s.sram     = s.setup_nv;               // R14
				tap_setup_pkg::START_AUTOCALIBRATION_CMD:    next_s.cal      = 1'b1;                     // R17
				tap_setup_pkg::SLEEP_ANALOG_CMD:             next_s.sleep    = 1'b1;                     // R18
				tap_setup_pkg::WAKE_ANALOG_CMD:              next_s.sleep    = 1'b0;                     // R18
				tap_setup_pkg::CLEAR_SETUP_MEMORY_CMD:       next_s.setup_nv = tap_setup_pkg::SETUP_RESET; // R19
				tap_setup_pkg::CLEAR_SIGNATURE_MEMORY_CMD:   next_s.sig_nv   = tap_setup_pkg::SIG_RESET;   // R19
				default:                                     next_s.lock     = next_s.lock;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s          <= '0;
			s.tap      <= tap_setup_pkg::TEST_RESET;
			s.instr    <= tap_setup_pkg::INSTR_RESET; // R5
			s.setup_nv <= tap_setup_pkg::SETUP_RESET;
			s.sig_nv   <= tap_setup_pkg::SIG_RESET;
			s.sram     <= tap_setup_pkg::SRAM_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	// All outputs come straight from the state register.
	assign o_tdo           = s.tdo;
	assign o_tdo_oe        = s.tdo_oe;
	assign o_control_sram  = s.sram;
	assign o_amp_hold_zero = s.cal;   // R17
	assign o_analog_sleep  = s.sleep; // R18
	assign o_readout_lock  = s.lock;
	assign o_instruction   = s.instr;

endmodule

// ---- verification/tap_host.sv ----
// Purpose: Behavioural test-port controller for the setup decoder bench.
// Assumes: Test clock of eight system clocks (400 ns), low for five and high for three.
// Notes:   Data in toggles whenever its value is a don't-care, so a stale bit never passes.
module tap_host (
	// System clock and port pins.
	input  wire logic i_clk, i_tdo,
	output logic      o_tck = 0, o_tms = 1, o_tdi = 0
);
	timeunit 1ns;
	timeprecision 1ns;
	// One test clock: pins change at the fall, data out is taken as the clock rises.
	task automatic tick(input logic m, d, output logic o);
		@(posedge i_clk) {o_tck, o_tms, o_tdi} <= {1'b0, m, d};
		repeat (5) @(posedge i_clk);
		o = i_tdo;
		o_tck <= 1;
		repeat (2) @(posedge i_clk);
	endtask
	// Idle to idle scan of n bits, lowest first; ir picks the instruction side.
	task automatic scan(input logic ir, input int n, input logic [127:0] d, output logic [127:0] q);
		logic o;
		q = '0;
		tick(1, ~o_tdi, o);
		if (ir) tick(1, ~o_tdi, o);
		repeat (2) tick(0, ~o_tdi, o);
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, d[i], o);
			q[i] = o;
		end
		tick(1, ~o_tdi, o);
		tick(0, ~o_tdi, o);
	endtask
	// Five ticks with mode high reach test-logic-reset from any state.
	task automatic rst(input logic idle);
		logic o;
		repeat (5) tick(1, ~o_tdi, o);
		if (idle) tick(0, ~o_tdi, o);
	endtask
endmodule

// ---- verification/tap_setup_instruction_decoder_props.sv ----
// Purpose: Port checks for the setup instruction decoder.
// Assumes: One clock domain; test clock high and low for three system clocks or more.
// Notes:   Cause checks assume the command queue has drained before a new instruction.
module tap_setup_props (
	// Clock, reset and watched ports.
	input wire logic         i_clk, i_reset, i_tck, i_cal_done, i_nv_busy,
	input wire logic         o_tdo, o_tdo_oe, o_amp_hold_zero, o_analog_sleep, o_readout_lock,
	input wire logic [111:0] o_control_sram,
	input wire logic [5:0]   o_instruction
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	reset_values_a: assert property ($fell(i_reset) |-> o_instruction == 6'h0d && !o_readout_lock)
		else $error("Reset values wrong");
	tdo_at_fall_a: assert property ($changed({o_tdo, o_tdo_oe}) |-> !$past(i_tck) && !$past(i_tck, 2))
		else $error("Serial out moved off the clock fall");
	update_idle_a: assert property ($changed(o_instruction) |-> !o_tdo_oe)
		else $error("Instruction changed while shifting");
	busy_stall_a: assert property (i_nv_busy && $past(i_nv_busy) |=> $stable({o_analog_sleep, o_control_sram}))
		else $error("Command ran while busy");
	hold_keep_a: assert property (o_amp_hold_zero && !i_cal_done |=> o_amp_hold_zero)
		else $error("Hold dropped early");
	hold_end_a: assert property (o_amp_hold_zero && i_cal_done |=> !o_amp_hold_zero)
		else $error("Hold kept after done");
	sram_cause_a: assert property ($changed(o_control_sram) |-> o_instruction inside {6'h05, 6'h16})
		else $error("Control memory changed without a load");
	lock_cause_a: assert property ($changed(o_readout_lock) |-> o_instruction == (o_readout_lock ? 6'h11 : 6'h1d))
		else $error("Lock changed by wrong command");
	// Main scenarios reached.
	cover property ($rose(o_readout_lock));
	cover property ($changed(o_control_sram));
	cover property ($rose(o_analog_sleep));
endmodule
bind tap_setup_instruction_decoder tap_setup_props props (.*);

// ---- verification/test_tap_setup_instruction_decoder.sv ----
// Purpose: Self-checking bench for the setup instruction decoder.
// Assumes: The host model makes the 400 ns test clock.
// Notes:   Rows check path lengths; later tests check memory, lock, power and the queue.
module test_tap_setup_instruction_decoder;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0]  ID  = 32'h1234_5671; // Arbitrary value.
	localparam logic [127:0] PAT = {8{16'h6b2c}};
	logic [13:0]  rows [9] = '{14'h3f01, 14'h2001, 14'h0001, 14'h1e01, 14'h0701, 14'h0d20, 14'h0170, 14'h0228, 14'h0310};
	logic         i_clk = 0, i_reset = 1, i_cal_done = 0, i_nv_busy = 0, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe;
	logic         o_amp_hold_zero, o_analog_sleep, o_readout_lock;
	logic [111:0] o_control_sram;
	logic [5:0]   o_instruction;
	logic [127:0] q;
	int           fails = 0, comparisons = 0, cycles = 0;
	// Design and host.
	tap_setup_instruction_decoder #(.ID_VALUE(ID)) dut (.*);
	tap_host host (.i_clk(i_clk), .i_tdo(o_tdo), .o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi));
	// Clock, and a ceiling about two and a half times the expected run.
	initial forever #25 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fails++;
			conclude();
		end
	end
	task automatic check(input string n, input logic [127:0] s, input logic [127:0] e);
		comparisons++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// Each instruction scan waits out the switching time, so deferred effects are due.
	task automatic ir(input logic [5:0] c);
		host.scan(1, 6, 128'(c), q);
		repeat (tap_setup_pkg::SWITCH_CYCLES - 3) @(posedge i_clk);
	endtask
	task automatic dr(input int n, input logic [127:0] d);
		host.scan(0, n, d, q);
	endtask
	// Fetch f, select s and read n bits, refilling the register with ones.
	task automatic fetch(input logic [5:0] f, input logic [5:0] s, input int n);
		ir(f);
		ir(s);
		dr(n, '1);
	endtask
	initial begin
		repeat (16) @(posedge i_clk);
		i_reset <= 0;
		host.rst(1);
		dr(32, PAT);
		check("id", 128'(q[31:0]), 128'(ID));
		$display("Test reset done");
		foreach (rows[i]) begin
			ir(rows[i][13:8]);
			check("capture", 128'(q[5:0]), 128'h0d);
			check("instruction", 128'(o_instruction), 128'(rows[i][13:8]));
			dr(rows[i][7:0] + 8, PAT);
			check("path", 128'(q[rows[i][7:0] +: 8]), 128'(PAT[7:0]));
			$display("Test row %0d done", i);
		end
		// Loads, restore, and a second write without clearing.
		ir(6'h01);
		dr(112, PAT);
		check("sram held", 128'(o_control_sram), '0);
		ir(6'h05);
		check("sram load", 128'(o_control_sram), 128'(PAT[111:0]));
		ir(6'h17);
		ir(6'h0c);
		ir(6'h01);
		dr(112, ~PAT);
		ir(6'h05);
		ir(6'h16);
		check("restore", 128'(o_control_sram), 128'(PAT[111:0]));
		ir(6'h0c);
		fetch(6'h06, 6'h01, 112);
		check("or write", q, 128'({112{1'b1}}));
		// Lock hides setup data until the bulk clear.
		ir(6'h11);
		check("lock", 128'(o_readout_lock), 128'h1);
		fetch(6'h06, 6'h01, 112);
		check("locked", q, '0);
		ir(6'h1d);
		check("unlock", 128'(o_readout_lock), '0);
		fetch(6'h06, 6'h01, 112);
		check("bulk", q, '0);
		// Calibration hold, power-down and wake.
		ir(6'h1c);
		check("hold", 128'(o_amp_hold_zero), 128'h1);
		i_cal_done <= 1;
		@(posedge i_clk);
		i_cal_done <= 0;
		repeat (2) @(posedge i_clk);
		check("hold end", 128'(o_amp_hold_zero), '0);
		ir(6'h12);
		check("sleep", 128'(o_analog_sleep), 128'h1);
		ir(6'h13);
		check("wake", 128'(o_analog_sleep), '0);
		// Memory busy: five commands are kept, the sixth is dropped.
		i_nv_busy <= 1;
		for (int i = 0; i < 6; i++) ir(i[0] ? 6'h13 : 6'h12);
		check("stalled", 128'(o_analog_sleep), '0);
		i_nv_busy <= 0;
		repeat (40) @(posedge i_clk);
		check("drained", 128'(o_analog_sleep), 128'h1);
		$display("Test side effects done");
		host.rst(0);
		conclude();
	end
endmodule
